// file: pkg/dbm_pkg.sv
// shared constants and types for the ddr byte-write-mask write path
// ---------------------------------------------------------------
// ---------------------------------------------------------------
package dbm_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int DBM_LANE_W     = 9;
  localparam int DBM_LANES      = 2;
  localparam int DBM_ADDR_W     = 20;
  localparam int DBM_FIFO_DEPTH = 16;

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic DBM_OE_N_RST  = 1'b1;
  localparam logic DBM_PIN_RST   = 1'b1;
  localparam logic DBM_FLAG_RST  = 1'b0;

  // ---------------------------------------------------------------
  // read sequencer
  // ---------------------------------------------------------------
  typedef enum logic [2:0]
  {
    DBM_RD_IDLE  = 3'b000,
    DBM_RD_WAIT1 = 3'b001,
    DBM_RD_WAIT2 = 3'b010,
    DBM_RD_BEAT0 = 3'b011,
    DBM_RD_BEAT1 = 3'b100,
    DBM_RD_TURN  = 3'b101
  } dbm_rd_state_t;

endpackage

// file: pkg/dbm_fifo_if.sv
// push and pop handshake between the write path and its commit fifo
interface dbm_fifo_if #(parameter int W = 8) ();
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;

  modport store (input in_valid, input in_data, input out_ready,
                 output in_ready, output out_valid, output out_data);
  modport user  (output in_valid, output in_data, output out_ready,
                 input in_ready, input out_valid, input out_data);
endinterface

// file: hw/dbm_fifo.sv
// commit fifo holding completed two-beat writes until the array takes them
module dbm_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = dbm_pkg::DBM_FIFO_DEPTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // queue ports
  dbm_fifo_if.store q
);
  import dbm_pkg::*;

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_reg [DEPTH];
  logic [AW:0]  wr_ptr_reg;
  logic [AW:0]  rd_ptr_reg;
  logic         full;
  logic         empty;
  logic         push;
  logic         pop;

  // ---------------------------------------------------------------
  // status
  // ---------------------------------------------------------------
  // extra pointer bit tells full from empty without a counter
  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                 (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign push  = q.in_valid && !full;
  assign pop   = q.out_ready && !empty;

  assign q.in_ready  = !full;
  assign q.out_valid = !empty;
  assign q.out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

  // ---------------------------------------------------------------
  // pointers and storage
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      wr_ptr_reg <= '0;
    else if (push)
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      rd_ptr_reg <= '0;
    else if (pop)
      rd_ptr_reg <= rd_ptr_reg + 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem_reg[wr_ptr_reg[AW-1:0]] <= q.in_data;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_FIFO_FULL_HOLDS:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    full && !pop |=> full && $stable(wr_ptr_reg))
  else $error("fifo took a word while full");

endmodule

// file: hw/dbm_byte_mask.sv
// ddr sram write path with per-beat byte-lane masking and burst read-out
module dbm_byte_mask #(
  parameter int LANES  = dbm_pkg::DBM_LANES,
  parameter int ADDR_W = dbm_pkg::DBM_ADDR_W,
  parameter int DEPTH  = dbm_pkg::DBM_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                                   sys_clk,
  input  wire logic                                   nrst,
  // memory bus clocks and controls
  input  wire logic                                   k_pin,
  input  wire logic                                   k_n_pin,
  input  wire logic                                   address_load_n,
  input  wire logic                                   read_write,
  input  wire logic [ADDR_W-1:0]                      addr_pin,
  input  wire logic [LANES-1:0]                       byte_write_select_n,
  // shared data pins
  input  wire logic [LANES*dbm_pkg::DBM_LANE_W-1:0]   dq_in,
  output      logic [LANES*dbm_pkg::DBM_LANE_W-1:0]   dq_out,
  output      logic                                   dq_oe_n,
  // flow control toward the controller
  output      logic                                   write_ready
);
  import dbm_pkg::*;

  localparam int W  = LANES * DBM_LANE_W;
  localparam int PW = 4 + ADDR_W + W + LANES;
  localparam int EW = ADDR_W + 2 * W + 2 * LANES;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // byte selects are active low; a low select enables its lane
  function automatic logic [LANES-1:0] lane_en(input logic [LANES-1:0] sel_n);
    return ~sel_n;
  endfunction

  function automatic logic [W-1:0] merge_lanes(input logic [W-1:0]     old_w,
                                               input logic [W-1:0]     new_w,
                                               input logic [LANES-1:0] en);
    logic [W-1:0] res;
    res = old_w;
    for (int l = 0; l < LANES; l++)
    begin
      if (en[l])
        res[l*DBM_LANE_W +: DBM_LANE_W] = new_w[l*DBM_LANE_W +: DBM_LANE_W];
    end
    return res;
  endfunction

  // ---------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------
  logic [PW-1:0]     pins_raw;
  logic [PW-1:0]     pins_meta_reg;
  logic [PW-1:0]     pins_sync_reg;
  logic              k_s;
  logic              kn_s;
  logic              ld_n_s;
  logic              rw_s;
  logic [ADDR_W-1:0] addr_s;
  logic [W-1:0]      dq_s;
  logic [LANES-1:0]  bws_s;
  logic              k_d_reg;
  logic              kn_d_reg;
  logic              k_rise;
  logic              kn_rise;

  assign pins_raw = {k_pin, k_n_pin, address_load_n, read_write,
                     addr_pin, dq_in, byte_write_select_n};

  // reset to all ones: clocks high, loads and selects idle, no false edge
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      pins_meta_reg <= '1;
      pins_sync_reg <= '1;
    end
    else
    begin
      pins_meta_reg <= pins_raw;
      pins_sync_reg <= pins_meta_reg;
    end
  end

  assign {k_s, kn_s, ld_n_s, rw_s, addr_s, dq_s, bws_s} = pins_sync_reg;

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      k_d_reg  <= DBM_PIN_RST;
      kn_d_reg <= DBM_PIN_RST;
    end
    else
    begin
      k_d_reg  <= k_s;
      kn_d_reg <= kn_s;
    end
  end

  // both clock rises are used: data beats ride on each of them
  assign k_rise  = k_s && !k_d_reg;
  assign kn_rise = kn_s && !kn_d_reg;

  // ---------------------------------------------------------------
  // write capture
  // ---------------------------------------------------------------
  dbm_fifo_if #(.W(EW)) cq ();

  logic              ld_wr;
  logic              wr_due_reg;
  logic              half_reg;
  logic              push_reg;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic [ADDR_W-1:0] beat_addr_reg;
  logic [W-1:0]      d0_reg;
  logic [W-1:0]      d1_reg;
  logic [LANES-1:0]  e0_reg;
  logic [LANES-1:0]  e1_reg;

  assign ld_wr       = k_rise && !ld_n_s && !rw_s;
  assign write_ready = cq.in_ready;

  // start cycle t: address latched, beat one due at the next rise
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      wr_due_reg <= DBM_FLAG_RST;
    else if (k_rise)
      wr_due_reg <= ld_wr;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      wr_addr_reg <= '0;
    else if (ld_wr)
      wr_addr_reg <= addr_s;
  end

  // first beat at the positive rise of t+1, its own selects with it
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      beat_addr_reg <= '0;
      d0_reg        <= '0;
      e0_reg        <= '0;
    end
    else if (k_rise && wr_due_reg)
    begin
      beat_addr_reg <= wr_addr_reg;
      d0_reg        <= dq_s;
      e0_reg        <= lane_en(bws_s);
    end
  end

  // second beat at the following negative rise, sampled afresh
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      d1_reg <= '0;
      e1_reg <= '0;
    end
    else if (kn_rise && half_reg)
    begin
      d1_reg <= dq_s;
      e1_reg <= lane_en(bws_s);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      half_reg <= DBM_FLAG_RST;
    else if (k_rise && wr_due_reg)
      half_reg <= 1'b1;
    else if (kn_rise)
      half_reg <= 1'b0;
  end

  // one push per burst, only once both beats are held
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      push_reg <= DBM_FLAG_RST;
    else
      push_reg <= kn_rise && half_reg;
  end

  assign cq.in_valid = push_reg;
  assign cq.in_data  = {beat_addr_reg, d1_reg, e1_reg, d0_reg, e0_reg};

  dbm_fifo #(
    .W     (EW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .q       (cq)
  );

  // ---------------------------------------------------------------
  // array and commit
  // ---------------------------------------------------------------
  logic [W-1:0]      mem0 [2**ADDR_W];
  logic [W-1:0]      mem1 [2**ADDR_W];
  logic [ADDR_W-1:0] c_addr;
  logic [W-1:0]      c_d0;
  logic [W-1:0]      c_d1;
  logic [LANES-1:0]  c_e0;
  logic [LANES-1:0]  c_e1;
  logic              fetch;
  logic              pop;

  assign {c_addr, c_d1, c_e1, c_d0, c_e0} = cq.out_data;
  // the read fetch owns the array for its cycle; commits wait
  assign cq.out_ready = !fetch;
  assign pop          = cq.out_valid && cq.out_ready;

  // burst word 0 goes to mem0, word 1 to mem1, both at the latched address
  always_ff @(posedge sys_clk)
  begin
    if (pop)
    begin
      mem0[c_addr] <= merge_lanes(mem0[c_addr], c_d0, c_e0);
      mem1[c_addr] <= merge_lanes(mem1[c_addr], c_d1, c_e1);
    end
  end

  // ---------------------------------------------------------------
  // read sequencer
  // ---------------------------------------------------------------
  dbm_rd_state_t     rd_state_reg;
  logic [ADDR_W-1:0] rd_addr_reg;
  logic [W-1:0]      rd_word0_reg;
  logic [W-1:0]      rd_word1_reg;
  logic              ld_rd;

  // a read load during a running read is not taken; reads do not overlap
  assign ld_rd = k_rise && !ld_n_s && rw_s && (rd_state_reg == DBM_RD_IDLE);
  assign fetch = k_rise && (rd_state_reg == DBM_RD_WAIT1);

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      rd_state_reg <= DBM_RD_IDLE;
    else
    begin
      unique case (rd_state_reg)
        DBM_RD_IDLE:  if (ld_rd) rd_state_reg <= DBM_RD_WAIT1;
        DBM_RD_WAIT1: if (k_rise) rd_state_reg <= DBM_RD_WAIT2;
        DBM_RD_WAIT2: if (k_rise) rd_state_reg <= DBM_RD_BEAT0;
        DBM_RD_BEAT0: if (kn_rise) rd_state_reg <= DBM_RD_BEAT1;
        DBM_RD_BEAT1: if (k_rise) rd_state_reg <= DBM_RD_TURN;
        DBM_RD_TURN:  if (kn_rise) rd_state_reg <= DBM_RD_IDLE;
        default:      rd_state_reg <= DBM_RD_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      rd_addr_reg <= '0;
    else if (ld_rd)
      rd_addr_reg <= addr_s;
  end

  always_ff @(posedge sys_clk)
  begin
    if (fetch)
    begin
      rd_word0_reg <= mem0[rd_addr_reg];
      rd_word1_reg <= mem1[rd_addr_reg];
    end
  end

  // word 0 on the negative rise, word 1 on the next positive rise
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      dq_out <= '0;
    else if (rd_state_reg == DBM_RD_BEAT0 && kn_rise)
      dq_out <= rd_word0_reg;
    else if (rd_state_reg == DBM_RD_BEAT1 && k_rise)
      dq_out <= rd_word1_reg;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      dq_oe_n <= DBM_OE_N_RST;
    else if (rd_state_reg == DBM_RD_BEAT0 && kn_rise)
      dq_oe_n <= 1'b0;
    else if (rd_state_reg == DBM_RD_TURN && kn_rise)
      dq_oe_n <= 1'b1;
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_wr_start;
    ld_wr;
  endsequence
  sequence s_beat0_take;
    k_rise && wr_due_reg;
  endsequence
  sequence s_beat1_take;
    kn_rise && half_reg;
  endsequence

  AST_START_ADDR:
  assert property (s_wr_start |=> wr_due_reg && wr_addr_reg == $past(addr_s))
  else $error("write start did not latch address");
  AST_BEAT0_TAKE:
  assert property (s_beat0_take |=> half_reg && beat_addr_reg == $past(wr_addr_reg)
                   && d0_reg == $past(dq_s))
  else $error("first beat not taken at latched address");
  AST_BEAT1_SEL:
  assert property (s_beat1_take |=> e1_reg == ~$past(bws_s) && $stable(e0_reg))
  else $error("second beat selects mixed with first");
  AST_COMMIT_PAIR:
  assert property (s_beat0_take ##1 (!kn_rise)[*1] |-> !push_reg)
  else $error("commit before second beat");
  AST_PUSH_AFTER_BEAT1:
  assert property (s_beat1_take |=> cq.in_valid
                   && cq.in_data == {beat_addr_reg, $past(dq_s), e1_reg, d0_reg, e0_reg})
  else $error("burst not pushed after second beat");
  AST_ALL_LANES:
  assert property (pop && (&c_e0) && (&c_e1)
                   |=> mem0[$past(c_addr)] == $past(c_d0) && mem1[$past(c_addr)] == $past(c_d1))
  else $error("full write did not store every lane");
  AST_ONE_LANE:
  assert property (pop && $onehot(c_e0) |=> mem0[$past(c_addr)]
                   == merge_lanes($past(mem0[c_addr]), $past(c_d0), $past(c_e0)))
  else $error("single lane write touched another lane");
  AST_NO_LANE:
  assert property (pop && c_e1 == '0 |=> mem1[$past(c_addr)] == $past(mem1[c_addr]))
  else $error("masked beat altered the array");
  AST_ANY_MIX:
  assert property (pop
                   |=> mem0[$past(c_addr)] == merge_lanes($past(mem0[c_addr]), $past(c_d0),
                                                          $past(c_e0))
                   && mem1[$past(c_addr)] == merge_lanes($past(mem1[c_addr]), $past(c_d1),
                                                         $past(c_e1)))
  else $error("lane merge wrong");
  AST_IDLE_HIZ:
  assert property (rd_state_reg inside {DBM_RD_IDLE, DBM_RD_WAIT1, DBM_RD_WAIT2,
                                        DBM_RD_BEAT0} |-> dq_oe_n)
  else $error("data pins driven outside a read burst");
  AST_READ_BEATS:
  assert property (rd_state_reg == DBM_RD_BEAT0 && kn_rise
                   |=> !dq_oe_n && dq_out == $past(rd_word0_reg))
  else $error("first read word not driven on negative rise");

endmodule

// file: verif/dbm_ctl_model.sv
// controller model driving the sram pins for write and read bursts
// ---------------------------------------------------------------
// controller model
// ---------------------------------------------------------------
module dbm_ctl_model #(
  parameter int LANES  = 2,
  parameter int ADDR_W = 4
) (
  // clock
  input  wire logic                                 sys_clk,
  // clocks and controls toward the sram
  output      logic                                 k_pin,
  output      logic                                 k_n_pin,
  output      logic                                 address_load_n,
  output      logic                                 read_write,
  output      logic [ADDR_W-1:0]                    addr_pin,
  output      logic [LANES-1:0]                     byte_write_select_n,
  // shared data wire
  output      logic [LANES*dbm_pkg::DBM_LANE_W-1:0] dq_drive,
  input  wire logic [LANES*dbm_pkg::DBM_LANE_W-1:0] dq_wire,
  input  wire logic                                 dq_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  import dbm_pkg::*;
  localparam int W    = LANES * DBM_LANE_W;
  // pin syncs need at least 3 cycles per half period
  localparam int HALF = 4;

  // clocks parked high between frames for the fastest restart
  initial
  begin
    k_pin               = 1'b1;
    k_n_pin             = 1'b1;
    address_load_n      = 1'b1;
    read_write          = 1'b1;
    addr_pin            = '0;
    byte_write_select_n = '1;
    dq_drive            = '0;
  end

  // one rise of k (sel 0) or k_n (sel 1), entered just after a sys_clk rise
  task automatic rise(input logic sel);
    if (sel)
      k_n_pin <= 1'b0;
    else
      k_pin <= 1'b0;
    repeat (HALF) @(posedge sys_clk);
    if (sel)
      k_n_pin <= 1'b1;
    else
      k_pin <= 1'b1;
    repeat (HALF) @(posedge sys_clk);
  endtask

  // sample mid-cycle, then realign to a rising edge
  task automatic look(output logic [W-1:0] d, output logic oe);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    d  = dq_wire;
    oe = dq_oe_n;
    @(posedge sys_clk);
  endtask

  task automatic write_burst(input logic [ADDR_W-1:0] a, input logic [W-1:0] d0,
                             input logic [LANES-1:0] s0, input logic [W-1:0] d1,
                             input logic [LANES-1:0] s1);
    @(posedge sys_clk);
    address_load_n      <= 1'b0;
    read_write          <= 1'b0;
    addr_pin            <= a;
    rise(1'b0);
    address_load_n      <= 1'b1;
    dq_drive            <= d0;
    byte_write_select_n <= s0;
    rise(1'b0);
    dq_drive            <= d1;
    byte_write_select_n <= s1;
    rise(1'b1);
    // released lines show the inverse so stale values are never trusted
    dq_drive            <= ~d1;
    byte_write_select_n <= ~s1;
    addr_pin            <= ~a;
  endtask

  task automatic read_burst(input logic [ADDR_W-1:0] a, output logic [W-1:0] w0,
                            output logic [W-1:0] w1, output logic oe0,
                            output logic oe1, output logic oe2);
    logic [W-1:0] spare;
    @(posedge sys_clk);
    address_load_n <= 1'b0;
    read_write     <= 1'b1;
    addr_pin       <= a;
    rise(1'b0);
    address_load_n <= 1'b1;
    addr_pin       <= ~a;
    rise(1'b0);
    rise(1'b0);
    rise(1'b1);
    look(w0, oe0);
    rise(1'b0);
    look(w1, oe1);
    rise(1'b1);
    look(spare, oe2);
  endtask
endmodule

// file: verif/dbm_byte_mask_bench.sv
// self-checking bench for the byte-masked write path, two and four lanes
// ---------------------------------------------------------------
// one design instance facing its controller model
// ---------------------------------------------------------------
module dbm_bench_pair #(
  parameter int LANES = 2
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst
);
  timeunit 1ns;
  timeprecision 1ps;
  import dbm_pkg::*;
  localparam int W = LANES * DBM_LANE_W;
  logic             k;
  logic             k_n;
  logic             ld_n;
  logic             rw;
  logic [3:0]       addr;
  logic [LANES-1:0] bws_n;
  logic [W-1:0]     drv;
  logic [W-1:0]     din;
  logic [W-1:0]     dout;
  logic             oe_n;
  logic             rdy;

  // shared wire: the sram wins while its enable is low
  assign din = (oe_n == 1'b0) ? dout : drv;

  dbm_byte_mask #(.LANES(LANES), .ADDR_W(4), .DEPTH(DBM_FIFO_DEPTH)) dut_u (
    .sys_clk(sys_clk), .nrst(nrst), .k_pin(k), .k_n_pin(k_n),
    .address_load_n(ld_n), .read_write(rw), .addr_pin(addr),
    .byte_write_select_n(bws_n), .dq_in(din), .dq_out(dout), .dq_oe_n(oe_n),
    .write_ready(rdy));

  dbm_ctl_model #(.LANES(LANES), .ADDR_W(4)) ctl_u (
    .sys_clk(sys_clk), .k_pin(k), .k_n_pin(k_n), .address_load_n(ld_n),
    .read_write(rw), .addr_pin(addr), .byte_write_select_n(bws_n),
    .dq_drive(drv), .dq_wire(din), .dq_oe_n(oe_n));
endmodule

// ---------------------------------------------------------------
// top of the bench
// ---------------------------------------------------------------
module dbm_byte_mask_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        nrst    = 1'b0;
  logic [8:0]  stamp   = 9'h000;
  int          failures = 0;
  int          n_checks = 0;
  logic [35:0] mem [2][16][2];

  always #20 sys_clk = ~sys_clk;

  dbm_bench_pair #(.LANES(2)) two_u (.sys_clk(sys_clk), .nrst(nrst));
  dbm_bench_pair #(.LANES(4)) four_u (.sys_clk(sys_clk), .nrst(nrst));

  task automatic report_and_stop();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // lanes with a high select keep the old contents
  function automatic logic [35:0] merge(input logic [35:0] old_w, input logic [35:0] new_w,
                                        input logic [3:0] sel_n);
    logic [35:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++)
      if (!sel_n[i])
        r[i*9 +: 9] = new_w[i*9 +: 9];
    return r;
  endfunction

  task automatic check_reset();
    @(negedge sys_clk);
    chk("oe after reset", 36'h1, {35'h0, two_u.oe_n});
    chk("dq after reset", 36'h0, {18'h0, two_u.dout});
    chk("oe4 after reset", 36'h1, {35'h0, four_u.oe_n});
    chk("ready after reset", 36'h1, {35'h0, four_u.rdy});
    chk("ready2 after reset", 36'h1, {35'h0, two_u.rdy});
  endtask

  // write one burst with per-beat selects, then read the location back
  task automatic mask_case(input int c, input logic [3:0] a, input logic [3:0] s0,
                           input logic [3:0] s1);
    logic [35:0] d0;
    logic [35:0] d1;
    logic [35:0] w0;
    logic [35:0] w1;
    logic        oe0;
    logic        oe1;
    logic        oe2;
    logic [3:0]  keep;
    stamp = stamp + 9'h035;
    d0    = {4{stamp}} ^ 36'h5a96c3d21;
    d1    = ~d0;
    keep  = (c == 0) ? 4'hc : 4'h0;
    if (c == 0)
      two_u.ctl_u.write_burst(a, d0[17:0], s0[1:0], d1[17:0], s1[1:0]);
    else
      four_u.ctl_u.write_burst(a, d0, s0, d1, s1);
    mem[c][a][0] = merge(mem[c][a][0], d0, s0 | keep);
    mem[c][a][1] = merge(mem[c][a][1], d1, s1 | keep);
    // committed bursts only become visible after the fifo drains
    repeat (12) @(posedge sys_clk);
    chk("ready after burst", 36'h1, {35'h0, (c == 0) ? two_u.rdy : four_u.rdy});
    w0 = '0;
    w1 = '0;
    if (c == 0)
      two_u.ctl_u.read_burst(a, w0[17:0], w1[17:0], oe0, oe1, oe2);
    else
      four_u.ctl_u.read_burst(a, w0, w1, oe0, oe1, oe2);
    chk("word0", mem[c][a][0], w0);
    chk("word1", mem[c][a][1], w1);
    chk("drive word0", 36'h0, {35'h0, oe0});
    chk("drive word1", 36'h0, {35'h0, oe1});
    chk("release", 36'h1, {35'h0, oe2});
  endtask

  initial
  begin
    mem = '{default: '0};
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check_reset();
    for (int a = 0; a < 4; a++)
      mask_case(0, a[3:0], 4'h0, 4'h0);
    for (int a = 0; a < 6; a++)
      mask_case(1, a[3:0], 4'h0, 4'h0);
    mask_case(0, 4'h1, 4'h2, 4'h1);
    mask_case(0, 4'h2, 4'h3, 4'h0);
    mask_case(0, 4'h3, 4'h1, 4'h3);
    for (int i = 0; i < 4; i++)
      mask_case(1, i[3:0], ~(4'h1 << i), ~(4'h1 << ((i + 1) % 4)));
    mask_case(1, 4'h4, 4'hf, 4'hf);
    mask_case(1, 4'h5, 4'h5, 4'ha);
    report_and_stop();
  end

  // about 1800 cycles expected; over sixteen times that means a hang
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    failures++;
    report_and_stop();
  end
endmodule
